// ==== rtl/cs_pkg.sv ====
// Constants, types and helpers shared by the core status block
package cs_pkg;

  localparam int AXI_AW = 12;
  localparam int AXI_DW = 32;

  // Register indices, whose byte address is four times the index, then the two interrupt register byte addresses
  localparam logic [8:0] IDX_WINDOW = 9'h180;
  localparam logic [8:0] IDX_STATUS = 9'h183;
  localparam logic [8:0] IDX_POINTER = 9'h184;
  localparam logic [AXI_AW-1:0] ADDR_IRQ_STAT = 12'h700;
  localparam logic [AXI_AW-1:0] ADDR_IRQ_MASK = 12'h704;

  // Status bit positions
  localparam int BIT_IND_BANK = 7;
  localparam int BIT_DBANK_HI = 6;
  localparam int BIT_DBANK_LO = 5;
  localparam int BIT_WDT_N = 4;
  localparam int BIT_SLEEP_N = 3;
  localparam int BIT_Z = 2;
  localparam int BIT_HALF = 1;
  localparam int BIT_C = 0;
  localparam logic [7:0] STATUS_RST = 8'h18;

  // Flag mask order is {zero, half carry, carry}
  localparam int FM_Z = 2;
  localparam int FM_HALF = 1;
  localparam int FM_C = 0;

  // Interrupt events
  localparam int IRQ_W = 3;
  localparam int EV_WDT = 0;
  localparam int EV_SLEEP = 1;
  localparam int EV_ZERO = 2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [10:0] {
    CS_ADD_W_FILE = 11'h001,
    CS_ADD_LITERAL = 11'h002,
    CS_SUB_W_FILE = 11'h004,
    CS_SUB_FROM_LITERAL = 11'h008,
    CS_ROTATE_RIGHT = 11'h010,
    CS_ROTATE_LEFT = 11'h020,
    CS_CLEAR_FILE = 11'h040,
    CS_AND_W_FILE = 11'h080,
    CS_MOVE_W_FILE = 11'h100,
    CS_WATCHDOG_CLEAR = 11'h200,
    CS_SLEEP = 11'h400
  } cs_op_t;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] pointer;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [7:0] result;
    logic result_valid;
    logic aw_held;
    logic [AXI_AW-1:0] awaddr;
    logic w_held;
    logic [7:0] wbyte;
    logic wlane;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rbyte;
    logic [1:0] rresp;
  } cs_state_t;

  function automatic logic [AXI_AW-1:0] cs_byte_addr(input logic [8:0] idx);
    cs_byte_addr = {1'b0, idx, 2'b00};
  endfunction : cs_byte_addr

  function automatic logic [2:0] cs_flag_mask(input cs_op_t op);
    case (op)
      CS_ADD_W_FILE, CS_ADD_LITERAL, CS_SUB_W_FILE, CS_SUB_FROM_LITERAL: cs_flag_mask = 3'h7;
      CS_ROTATE_RIGHT, CS_ROTATE_LEFT: cs_flag_mask = 3'h1;
      CS_CLEAR_FILE, CS_AND_W_FILE: cs_flag_mask = 3'h4;
      default: cs_flag_mask = 3'h0;
    endcase
  endfunction : cs_flag_mask

endpackage : cs_pkg

// ==== rtl/cs_if.sv ====
// Internal buses between the status block and its ALU and address former
`timescale 1ns/1ps
`default_nettype none
interface cs_alu_if;
  import cs_pkg::*;
  cs_op_t op;
  logic [7:0] w;
  logic [7:0] f;
  logic cin;
  logic [7:0] res;
  logic z;
  logic hc;
  logic c;
  modport core (output op, w, f, cin, input res, z, hc, c);
  modport alu (input op, w, f, cin, output res, z, hc, c);
endinterface : cs_alu_if

interface cs_addr_if;
  logic ind_bank;
  logic [1:0] dir_bank;
  logic [7:0] ptr;
  logic [6:0] field;
  logic [8:0] direct;
  logic [8:0] indirect;
  logic [8:0] data_addr;
  modport core (output ind_bank, dir_bank, ptr, field, input direct, indirect, data_addr);
  modport gen (input ind_bank, dir_bank, ptr, field, output direct, indirect, data_addr);
endinterface : cs_addr_if
`default_nettype wire

// ==== rtl/cs_alu.sv ====
// Byte ALU producing the result and the three arithmetic flags
`timescale 1ns/1ps
`default_nettype none
module cs_alu (
  cs_alu_if.alu bus
);
  import cs_pkg::*;
  logic sub;
  logic [7:0] opnd;
  logic [4:0] half;
  logic [8:0] sum;

  always_comb begin
    // Subtraction adds the two's complement, so carries mean no borrow
    sub = (bus.op == CS_SUB_W_FILE) || (bus.op == CS_SUB_FROM_LITERAL);
    opnd = sub ? ~bus.w : bus.w;
    half = {1'b0, bus.f[3:0]} + {1'b0, opnd[3:0]} + {4'h0, sub};
    sum = {1'b0, bus.f} + {1'b0, opnd} + {8'h00, sub};
    bus.res = bus.f;
    bus.c = bus.cin;
    bus.hc = 1'b0;
    case (bus.op)
      CS_ADD_W_FILE, CS_ADD_LITERAL, CS_SUB_W_FILE, CS_SUB_FROM_LITERAL: begin
        bus.res = sum[7:0];
        bus.hc = half[4];
        bus.c = sum[8];
      end
      CS_ROTATE_RIGHT: begin
        bus.res = {bus.cin, bus.f[7:1]};
        bus.c = bus.f[0];
      end
      CS_ROTATE_LEFT: begin
        bus.res = {bus.f[6:0], bus.cin};
        bus.c = bus.f[7];
      end
      CS_CLEAR_FILE: bus.res = 8'h00;
      CS_AND_W_FILE: bus.res = bus.w & bus.f;
      CS_MOVE_W_FILE: bus.res = bus.w;
      default: bus.res = bus.f;
    endcase
    bus.z = (bus.res == 8'h00);
  end
endmodule : cs_alu
`default_nettype wire

// ==== rtl/cs_addr_gen.sv ====
// Forms direct and indirect 9-bit data memory addresses from the bank bits
`timescale 1ns/1ps
`default_nettype none
module cs_addr_gen (
  cs_addr_if.gen bus
);
  import cs_pkg::*;
  localparam logic [6:0] WINDOW_LOW = IDX_WINDOW[6:0];

  // Bank bits 00..11 place the 7-bit field at 000h, 080h, 100h, 180h
  assign bus.direct = {bus.dir_bank, bus.field};
  // Bank bit 1 reaches 100h-1FFh, 0 reaches 000h-0FFh
  assign bus.indirect = {bus.ind_bank, bus.ptr};
  // The window location appears in every bank
  assign bus.data_addr = (bus.field == WINDOW_LOW) ? bus.indirect : bus.direct;
endmodule : cs_addr_gen
`default_nettype wire

// ==== rtl/cs_core_status.sv ====
// Core status and bank select register with AXI4-Lite access and interrupt
// Summary of operation
// - Status register is a normal instruction destination
// - Flag-setting instructions override written flag bits
// - Timeout and sleep flags ignore all writes
// - Clear-file on status clears banks, sets zero
// - Bit 7 selects indirect upper or lower half
// - Bits 6-5 select one of four direct banks
// - Timeout flag set by clear/sleep, cleared on expiry
// - Sleep flag set by clear, cleared by sleep
// - Zero flag follows zero result
// - Half carry is carry out of bit 3
// - Carry is carry out of bit 7
// - Subtract via two's complement; carries mean no-borrow
// - Rotates load carry with the bit shifted out
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module cs_core_status (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [cs_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [cs_pkg::AXI_DW-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [cs_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [cs_pkg::AXI_DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic exec_valid,
  input wire cs_pkg::cs_op_t exec_op,
  input wire logic [7:0] exec_w,
  input wire logic [7:0] exec_f,
  input wire logic [6:0] exec_field,
  input wire logic exec_dest_status,
  input wire logic exec_dest_pointer,
  input wire logic wdt_timeout,
  output logic [7:0] result,
  output logic result_valid,
  output logic [8:0] data_addr,
  output logic [8:0] direct_addr,
  output logic [8:0] indirect_addr,
  output logic [7:0] status_out,
  output logic irq
);
  import cs_pkg::*;

  localparam cs_state_t RST = '{status: STATUS_RST, default: '0};
  localparam logic [AXI_AW-1:0] A_WINDOW = cs_byte_addr(IDX_WINDOW);
  localparam logic [AXI_AW-1:0] A_STATUS = cs_byte_addr(IDX_STATUS);
  localparam logic [AXI_AW-1:0] A_POINTER = cs_byte_addr(IDX_POINTER);

  cs_state_t r_reg;
  cs_state_t r_next;
  logic wr_go;
  logic [2:0] fl;
  logic [IRQ_W-1:0] ev;

  cs_alu_if alu_bus ();
  cs_addr_if addr_bus ();

  cs_alu u_alu (
    .bus(alu_bus.alu)
  );

  cs_addr_gen u_addr (
    .bus(addr_bus.gen)
  );

  assign alu_bus.op = exec_op;
  assign alu_bus.w = exec_w;
  assign alu_bus.f = exec_f;
  assign alu_bus.cin = r_reg.status[BIT_C];
  assign addr_bus.ind_bank = r_reg.status[BIT_IND_BANK];
  assign addr_bus.dir_bank = r_reg.status[BIT_DBANK_HI:BIT_DBANK_LO];
  assign addr_bus.ptr = r_reg.pointer;
  assign addr_bus.field = exec_field;

  // Write happens once address and data are both held, in either order
  assign wr_go = r_reg.aw_held && r_reg.w_held && !r_reg.bvalid;
  assign fl = cs_flag_mask(exec_op);

  always_comb begin
    r_next = r_reg;
    r_next.result_valid = 1'b0;
    ev = '0;
    if (s_axi_awvalid && s_axi_awready) begin
      r_next.aw_held = 1'b1;
      r_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      r_next.w_held = 1'b1;
      r_next.wbyte = s_axi_wdata[7:0];
      r_next.wlane = s_axi_wstrb[0];
    end
    if (r_reg.bvalid && s_axi_bready) begin
      r_next.bvalid = 1'b0;
    end
    if (wr_go) begin
      r_next.aw_held = 1'b0;
      r_next.w_held = 1'b0;
      r_next.bvalid = 1'b1;
      r_next.bresp = RESP_OKAY;
      case (r_reg.awaddr)
        // The window is not storage here: writes are accepted and dropped
        A_WINDOW: r_next.bresp = RESP_OKAY;
        A_STATUS: begin
          if (r_reg.wlane) begin
            r_next.status[BIT_IND_BANK:BIT_DBANK_LO] = r_reg.wbyte[BIT_IND_BANK:BIT_DBANK_LO];
            r_next.status[BIT_Z:BIT_C] = r_reg.wbyte[BIT_Z:BIT_C];
          end
        end
        A_POINTER: begin
          if (r_reg.wlane) begin
            r_next.pointer = r_reg.wbyte;
          end
        end
        ADDR_IRQ_STAT: begin
          if (r_reg.wlane) begin
            r_next.irq_stat = r_reg.irq_stat & ~r_reg.wbyte[IRQ_W-1:0];
          end
        end
        ADDR_IRQ_MASK: begin
          if (r_reg.wlane) begin
            r_next.irq_mask = r_reg.wbyte[IRQ_W-1:0];
          end
        end
        default: r_next.bresp = RESP_SLVERR;
      endcase
    end
    if (s_axi_arvalid && s_axi_arready) begin
      r_next.rvalid = 1'b1;
      r_next.rresp = RESP_OKAY;
      case (s_axi_araddr)
        A_WINDOW: r_next.rbyte = 8'h00;
        A_STATUS: r_next.rbyte = r_reg.status;
        A_POINTER: r_next.rbyte = r_reg.pointer;
        ADDR_IRQ_STAT: r_next.rbyte = {{(8-IRQ_W){1'b0}}, r_reg.irq_stat};
        ADDR_IRQ_MASK: r_next.rbyte = {{(8-IRQ_W){1'b0}}, r_reg.irq_mask};
        default: begin
          r_next.rbyte = 8'h00;
          r_next.rresp = RESP_SLVERR;
        end
      endcase
    end else if (r_reg.rvalid && s_axi_rready) begin
      r_next.rvalid = 1'b0;
    end
    // Core execution comes after the bus write so the instruction wins
    if (exec_valid) begin
      r_next.result = alu_bus.res;
      r_next.result_valid = 1'b1;
      if (exec_dest_status) begin
        r_next.status[BIT_IND_BANK:BIT_DBANK_LO] = alu_bus.res[BIT_IND_BANK:BIT_DBANK_LO];
        if (fl == 3'h0) begin
          r_next.status[BIT_Z:BIT_C] = alu_bus.res[BIT_Z:BIT_C];
        end
      end
      if (exec_dest_pointer) begin
        r_next.pointer = alu_bus.res;
      end
      if (fl[FM_Z]) begin
        r_next.status[BIT_Z] = alu_bus.z;
      end
      if (fl[FM_HALF]) begin
        r_next.status[BIT_HALF] = alu_bus.hc;
      end
      if (fl[FM_C]) begin
        r_next.status[BIT_C] = alu_bus.c;
      end
      if (exec_op == CS_WATCHDOG_CLEAR) begin
        r_next.status[BIT_WDT_N] = 1'b1;
        r_next.status[BIT_SLEEP_N] = 1'b1;
      end
      if (exec_op == CS_SLEEP) begin
        r_next.status[BIT_WDT_N] = 1'b1;
        r_next.status[BIT_SLEEP_N] = 1'b0;
        ev[EV_SLEEP] = 1'b1;
      end
      ev[EV_ZERO] = fl[FM_Z] & alu_bus.z;
    end
    // Expiry beats a same-cycle clear instruction
    if (wdt_timeout) begin
      r_next.status[BIT_WDT_N] = 1'b0;
      ev[EV_WDT] = 1'b1;
    end
    // Events are ORed after the software clear, so a set is never lost
    r_next.irq_stat = r_next.irq_stat | ev;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_reg <= RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign s_axi_awready = !r_reg.aw_held;
  assign s_axi_wready = !r_reg.w_held;
  assign s_axi_bvalid = r_reg.bvalid;
  assign s_axi_bresp = r_reg.bresp;
  assign s_axi_arready = !r_reg.rvalid;
  assign s_axi_rvalid = r_reg.rvalid;
  assign s_axi_rresp = r_reg.rresp;
  assign s_axi_rdata = {24'h000000, r_reg.rbyte};
  assign result = r_reg.result;
  assign result_valid = r_reg.result_valid;
  assign status_out = r_reg.status;
  assign direct_addr = addr_bus.direct;
  assign indirect_addr = addr_bus.indirect;
  assign data_addr = addr_bus.data_addr;
  assign irq = |(r_reg.irq_stat & r_reg.irq_mask);

  // Checking helpers
  logic [8:0] add_chk;
  logic [4:0] half_chk;
  logic sub_nb;
  assign add_chk = {1'b0, exec_w} + {1'b0, exec_f};
  assign half_chk = {1'b0, exec_w[3:0]} + {1'b0, exec_f[3:0]};
  assign sub_nb = (exec_f >= exec_w);

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_flags_readonly: assert property (
    !wdt_timeout && !(exec_valid && (exec_op == CS_WATCHDOG_CLEAR || exec_op == CS_SLEEP))
    |=> $stable(status_out[BIT_WDT_N:BIT_SLEEP_N]))
    else $error("timeout or sleep flag changed without cause");
  a_dest_write: assert property (
    exec_valid && exec_dest_status && exec_op == CS_MOVE_W_FILE && !wdt_timeout
    |=> status_out[7:5] == $past(exec_w[7:5]) && status_out[2:0] == $past(exec_w[2:0]))
    else $error("move to status did not land");
  a_clear_status: assert property (
    exec_valid && exec_dest_status && exec_op == CS_CLEAR_FILE && !wr_go
    |=> status_out[7:5] == 3'h0 && status_out[BIT_Z]
    && status_out[1:0] == $past(status_out[1:0]))
    else $error("clear of status gave wrong bits");
  a_indirect_map: assert property (
    exec_field == IDX_WINDOW[6:0] |-> data_addr == {status_out[BIT_IND_BANK], r_reg.pointer})
    else $error("window access not indirect");
  a_zero_flag: assert property (
    exec_valid && fl[FM_Z] |=> status_out[BIT_Z] == (result == 8'h00) && result_valid)
    else $error("zero flag disagrees with result");
  a_add_carry: assert property (
    exec_valid && exec_op == CS_ADD_W_FILE
    |=> status_out[BIT_C] == $past(add_chk[8]) && status_out[BIT_HALF] == $past(half_chk[4]))
    else $error("add carry or half carry wrong");
  a_sub_borrow: assert property (
    exec_valid && exec_op == CS_SUB_W_FILE |=> status_out[BIT_C] == $past(sub_nb))
    else $error("subtract carry is not inverted borrow");
  a_rotate_carry: assert property (
    exec_valid && exec_op == CS_ROTATE_RIGHT
    |=> status_out[BIT_C] == $past(exec_f[0]) && result[7] == $past(status_out[BIT_C]))
    else $error("rotate right carry wrong");
  a_timeout_flag: assert property (
    wdt_timeout |=> !status_out[BIT_WDT_N]
    ##1 (status_out[BIT_WDT_N] == $past(r_next.status[BIT_WDT_N])))
    else $error("timeout did not clear flag");
  a_sleep_flag: assert property (
    exec_valid && exec_op == CS_SLEEP && !wdt_timeout
    |=> !status_out[BIT_SLEEP_N] && status_out[BIT_WDT_N] && irq_stat_sleep())
    else $error("sleep flags wrong");
  a_bank_direct: assert property (
    exec_field != IDX_WINDOW[6:0] |-> data_addr[8:7] == status_out[BIT_DBANK_HI:BIT_DBANK_LO])
    else $error("direct bank bits not applied");

  function automatic logic irq_stat_sleep();
    irq_stat_sleep = r_reg.irq_stat[EV_SLEEP];
  endfunction : irq_stat_sleep

  c_clear_status: cover property (exec_valid && exec_dest_status && exec_op == CS_CLEAR_FILE);
  c_timeout: cover property (wdt_timeout ##1 irq);
  c_sleep: cover property (exec_valid && exec_op == CS_SLEEP);
  c_bus_write: cover property (wr_go && r_reg.awaddr == A_STATUS);
endmodule : cs_core_status
`default_nettype wire

// ==== verification/cs_core_model.sv ====
// Behavioural instruction-execution side that feeds the status block
`timescale 1ns/1ps
`default_nettype none
module cs_core_model (
  input wire logic aclk,
  output logic exec_valid,
  output cs_pkg::cs_op_t exec_op,
  output logic [7:0] exec_w,
  output logic [7:0] exec_f,
  output logic [6:0] exec_field,
  output logic exec_dest_status,
  output logic exec_dest_pointer,
  output logic wdt_timeout
);
  import cs_pkg::*;

  initial begin
    exec_valid = 1'b0;
    exec_op = CS_MOVE_W_FILE;
    exec_w = 8'h00;
    exec_f = 8'h00;
    exec_field = 7'h01;
    exec_dest_status = 1'b0;
    exec_dest_pointer = 1'b0;
    wdt_timeout = 1'b0;
  end

  task automatic run(input cs_op_t op, input logic [7:0] w, input logic [7:0] f,
                     input logic ds);
    @(posedge aclk);
    exec_valid <= 1'b1;
    exec_op <= op;
    exec_w <= w;
    exec_f <= f;
    exec_dest_status <= ds;
    @(posedge aclk);
    exec_valid <= 1'b0;
    exec_dest_status <= 1'b0;
    // Operands go stale after the pulse so a late sample cannot pass
    exec_w <= ~w;
    exec_f <= ~f;
  endtask : run

  task automatic set_field(input logic [6:0] fl);
    @(posedge aclk);
    exec_field <= fl;
  endtask : set_field

  task automatic timeout_pulse();
    @(posedge aclk);
    wdt_timeout <= 1'b1;
    @(posedge aclk);
    wdt_timeout <= 1'b0;
  endtask : timeout_pulse
endmodule : cs_core_model
`default_nettype wire

// ==== verification/cpu_status_bank_select_register_bench.sv ====
// Self-checking bench for the core status block
`timescale 1ns/1ps
`default_nettype none
module cpu_status_bank_select_register_bench;
  import cs_pkg::*;
  localparam logic [11:0] A_WIN = {1'b0, IDX_WINDOW, 2'b00};
  localparam logic [11:0] A_ST = {1'b0, IDX_STATUS, 2'b00};
  localparam logic [11:0] A_PTR = {1'b0, IDX_POINTER, 2'b00};
  logic aclk, aresetn;
  logic [11:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp, resp;
  logic exec_valid, exec_dest_status, exec_dest_pointer, wdt_timeout, result_valid, irq;
  cs_op_t exec_op;
  logic [7:0] exec_w, exec_f, result, status_out, rd;
  logic [6:0] exec_field;
  logic [8:0] data_addr, direct_addr, indirect_addr;
  int err_count = 0;
  int n_tests = 0;

  cs_core_status dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .exec_valid(exec_valid), .exec_op(exec_op),
    .exec_w(exec_w), .exec_f(exec_f), .exec_field(exec_field),
    .exec_dest_status(exec_dest_status), .exec_dest_pointer(exec_dest_pointer),
    .wdt_timeout(wdt_timeout), .result(result), .result_valid(result_valid),
    .data_addr(data_addr), .direct_addr(direct_addr), .indirect_addr(indirect_addr),
    .status_out(status_out), .irq(irq));

  cs_core_model core (.aclk(aclk), .exec_valid(exec_valid), .exec_op(exec_op),
    .exec_w(exec_w), .exec_f(exec_f), .exec_field(exec_field),
    .exec_dest_status(exec_dest_status), .exec_dest_pointer(exec_dest_pointer),
    .wdt_timeout(wdt_timeout));

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Handshakes are read at the rising edge, before that edge's register updates land
  task automatic axw(input logic [11:0] a, input logic [7:0] d);
    logic pa, pw, pb;
    int n;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h0, d};
    wvalid <= 1'b1;
    bready <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    pb = 1'b1;
    n = 0;
    while (pb && n < 100) begin
      @(posedge aclk);
      if (pa && awready) begin
        pa = 1'b0;
        awvalid <= 1'b0;
      end
      if (pw && wready) begin
        pw = 1'b0;
        wvalid <= 1'b0;
      end
      if (bvalid) begin
        pb = 1'b0;
        resp = bresp;
        bready <= 1'b0;
      end
      n++;
    end
    if (pb) err_count++;
  endtask : axw

  task automatic axr(input logic [11:0] a);
    logic pa, hr;
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    pa = 1'b1;
    hr = 1'b0;
    n = 0;
    while (!hr && n < 100) begin
      @(posedge aclk);
      if (rvalid && !pa) begin
        hr = 1'b1;
        rd = rdata[7:0];
        resp = rresp;
        rready <= 1'b0;
        if (rdata[31:8] !== 24'h0) err_count++;
      end
      if (pa && arready) begin
        pa = 1'b0;
        arvalid <= 1'b0;
      end
      n++;
    end
    if (!hr) err_count++;
  endtask : axr

  task automatic rchk(input logic [11:0] a, input logic [7:0] e, input logic [1:0] r);
    axr(a);
    chk(rd, e);
    chk(resp, r);
  endtask : rchk

  task automatic ex(input cs_op_t op, input logic [7:0] w, input logic [7:0] f,
                    input logic ds, input logic [7:0] res, input logic [7:0] st);
    core.run(op, w, f, ds);
    #1;
    chk(result_valid, 1'b1);
    if (op != CS_SLEEP && op != CS_WATCHDOG_CLEAR) chk(result, res);
    chk(status_out, st);
  endtask : ex

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish

  initial begin
    #150000;
    err_count++;
    tally_and_finish();
  end

  initial begin
    aresetn = 1'b0;
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(A_ST, 8'h18, RESP_OKAY);
    rchk(A_PTR, 8'h00, RESP_OKAY);
    rchk(ADDR_IRQ_STAT, 8'h00, RESP_OKAY);
    rchk(A_WIN, 8'h00, RESP_OKAY);
    rchk(12'h7FC, 8'h00, RESP_SLVERR);
    $display("reset and map test done");
    axw(A_ST, 8'h00);
    rchk(A_ST, 8'h18, RESP_OKAY);
    core.set_field(7'h55);
    for (int i = 0; i < 4; i++) begin
      axw(A_ST, {1'b0, i[1:0], 5'h00});
      chk(direct_addr, {i[1:0], 7'h55});
    end
    axw(A_ST, 8'h80);
    axw(A_PTR, 8'hA5);
    chk(indirect_addr, 9'h1A5);
    core.set_field(7'h00);
    #1;
    chk(data_addr, 9'h1A5);
    axw(A_ST, 8'h00);
    chk(indirect_addr, 9'h0A5);
    $display("bank select test done");
    ex(CS_ADD_W_FILE, 8'h0F, 8'h01, 1'b0, 8'h10, 8'h1A);
    ex(CS_ADD_LITERAL, 8'hFF, 8'h01, 1'b0, 8'h00, 8'h1F);
    ex(CS_SUB_W_FILE, 8'h03, 8'h05, 1'b0, 8'h02, 8'h1B);
    ex(CS_SUB_FROM_LITERAL, 8'h05, 8'h03, 1'b0, 8'hFE, 8'h18);
    ex(CS_SUB_W_FILE, 8'h01, 8'h10, 1'b0, 8'h0F, 8'h19);
    ex(CS_ROTATE_RIGHT, 8'h00, 8'h02, 1'b0, 8'h81, 8'h18);
    ex(CS_ROTATE_LEFT, 8'h00, 8'h81, 1'b0, 8'h02, 8'h19);
    ex(CS_ADD_W_FILE, 8'h60, 8'h20, 1'b1, 8'h80, 8'h98);
    ex(CS_MOVE_W_FILE, 8'h3D, 8'h00, 1'b1, 8'h3D, 8'h3D);
    axw(A_ST, 8'hE3);
    rchk(A_ST, 8'hFB, RESP_OKAY);
    ex(CS_CLEAR_FILE, 8'h00, 8'hAA, 1'b1, 8'h00, 8'h1F);
    $display("flag test done");
    ex(CS_SLEEP, 8'h00, 8'h00, 1'b0, 8'h00, 8'h17);
    core.timeout_pulse();
    #1;
    chk(status_out, 8'h07);
    axw(A_ST, 8'h18);
    rchk(A_ST, 8'h00, RESP_OKAY);
    ex(CS_WATCHDOG_CLEAR, 8'h00, 8'h00, 1'b0, 8'h00, 8'h18);
    $display("power status test done");
    rchk(ADDR_IRQ_STAT, 8'h07, RESP_OKAY);
    chk(irq, 1'b0);
    axw(ADDR_IRQ_MASK, 8'h02);
    rchk(ADDR_IRQ_MASK, 8'h02, RESP_OKAY);
    chk(irq, 1'b1);
    axw(ADDR_IRQ_STAT, 8'h02);
    chk(irq, 1'b0);
    rchk(ADDR_IRQ_STAT, 8'h05, RESP_OKAY);
    axw(ADDR_IRQ_STAT, 8'h05);
    rchk(ADDR_IRQ_STAT, 8'h00, RESP_OKAY);
    $display("interrupt test done");
    tally_and_finish();
  end
endmodule : cpu_status_bank_select_register_bench
`default_nettype wire
